// [hw/codec_serial_pkg.sv]
// Constants shared by the codec serial frame and slot engine.
// Assumes APB byte addressing with one 32-bit word per register.
package codec_serial_pkg;

   // Register byte offsets
   localparam logic [7:0] ctrl_one_off = 8'h00;
   localparam logic [7:0] ctrl_three_off = 8'h04;
   localparam logic [7:0] tx_slot_enable_off = 8'h08;
   localparam logic [7:0] rx_slot_enable_off = 8'h0C;
   localparam logic [7:0] status_off = 8'h10;
   localparam logic [3:0] tx_buf_page = 4'h2;
   localparam logic [3:0] rx_buf_page = 4'h3;

   // Field positions in interface_control_one
   localparam int en_bit = 0;
   localparam int fs_dir_bit = 1;
   localparam int fmt_lo = 2;
   localparam int justify_bit = 4;
   localparam int idle_mode_bit = 5;
   localparam int edge_sel_bit = 6;
   localparam int bclk_dir_bit = 7;
   localparam int blen_lo = 8;
   localparam int wlen_lo = 10;
   localparam int period_lo = 14;
   localparam int ctrl_one_w = 18;

   // Reset values
   localparam logic [17:0] ctrl_one_rst = 18'h0_0000;
   localparam logic [11:0] divider_rst = 12'h000;
   localparam logic [15:0] slot_en_rst = 16'h0000;

   // Frame sync formats
   localparam logic [1:0] fmt_multi = 2'h0;
   localparam logic [1:0] fmt_i2s = 2'h1;
   localparam logic [1:0] fmt_ac16 = 2'h2;
   localparam logic [1:0] fmt_ac20 = 2'h3;

   // Link-protocol slot shapes (last bit index, last slot index)
   localparam logic [4:0] tag_last_bit = 5'h0F;
   localparam logic [4:0] ac_last_bit = 5'h13;
   localparam logic [3:0] ac16_last_slot = 4'hC;
   localparam logic [3:0] ac20_last_slot = 4'hF;

   typedef enum logic {st_idle, st_run} phase_t;

endpackage : codec_serial_pkg

// [hw/bit_clock_gen.sv]
// Programmable bit clock time base.
// Assumes the divider is held at zero while the clock comes from outside.
`timescale 1ns/100ps
module bit_clock_gen
   import codec_serial_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Control
   input wire logic [11:0] divider,
   // Generated clock
   output logic clk_out
);

   logic [11:0] cnt_q;
   logic [11:0] cnt_d;
   logic clk_q;
   logic clk_d;

   // Half period is divider+1 pclk cycles
   always_comb begin
      cnt_d = cnt_q;
      clk_d = clk_q;
      if (divider == 12'h000) begin // R7
         cnt_d = 12'h000;
         clk_d = 1'b0;
      end else if (cnt_q >= divider) begin // R8
         cnt_d = 12'h000;
         clk_d = ~clk_q;
      end else begin
         cnt_d = cnt_q + 12'h001; // R6
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= 12'h000;
         clk_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         clk_q <= clk_d;
      end
   end

   assign clk_out = clk_q;

   bclk_off_a: assert property (@(posedge pclk) disable iff (!presetn) // R7
      divider == 12'h000 |=> !clk_q) else $error("bit clock runs with zero divider");
   bclk_half_a: assert property (@(posedge pclk) disable iff (!presetn) // R8
      (divider != 12'h000 && cnt_q < divider && $stable(divider)) |=> clk_q == $past(clk_q))
      else $error("bit clock toggled early");
   bclk_toggle_a: assert property (@(posedge pclk) disable iff (!presetn) // R8
      (divider != 12'h000 && cnt_q == divider) |=> clk_q != $past(clk_q))
      else $error("bit clock missed its toggle");

endmodule : bit_clock_gen

// [hw/codec_serial_engine.sv]
// Codec serial frame and slot engine with APB register slave.
// Assumes pins are synchronous to pclk; the bit clock is far slower than pclk.
//
// Notes on behaviour
// R1: Multi-channel slave: frame starts one bit clock after sync sampled high.
// R2: I2S slave: either sync edge starts a word one bit clock later.
// R3: AC-Link slave: tag and data slots start one bit clock after sync high.
// R4: Once a frame starts, further syncs are ignored until it ends.
// R5: Software sets frame period and word length to match the codec.
// R6: A 12-bit time base makes the bit clock.
// R7: Divider zero stops the bit clock; nonzero runs it.
// R8: Bit clock is the system clock over two times divider plus one.
// R9: External bit clock makes the divider irrelevant.
// R10: Sample on falling edge by default, rising when edge select is set.
// R11: Justify select starts data in the sync sampling cycle itself.
// R12: Enabled transmit slot loads the shadow word and advances the pointer.
// R13: Disabled transmit slots drive zero or float, per idle output mode.
// R14: Slot enables past the frame length do nothing.
// R15: Transmit words are left justified; unused low bits ignored.
// R16: Enabled receive slot stores the word in the shadow and advances.
// R17: Received short words sit left justified, one per 16-bit location.
// R18: Master emits sync on frame restart; slave restarts on incoming sync.
// R19: After the last slot, no buffering until the next sync.
// R20: One shared pointer advances for any slot enabled either way.
// R21: Pointer equal to buffer length wraps to zero and swaps shadows.
// R22: Receive slot width follows word length, 1 to 16 bits.
// R23: Sync direction clear makes master, set makes slave.
// R24: Word length field holds length minus one.
// R25: Format 10 is 16-bit AC-Link, 11 is 20-bit AC-Link.
// R26: Every shadow transfer raises the buffer event output.
// R27: Sync is sampled on the same edge as serial input data.
`timescale 1ns/100ps
module codec_serial_engine
   import codec_serial_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Bit clock pin
   input wire logic bit_clk_in,
   output logic bit_clk_out,
   output logic bit_clk_oe_n,
   // Frame sync pin
   input wire logic frame_sync_in,
   output logic frame_sync_out,
   output logic frame_sync_oe_n,
   // Serial data pins
   input wire logic serial_in_pin,
   output logic serial_out_pin,
   output logic serial_out_oe_n,
   // Shadow transfer event
   output logic buffer_event
);

   // Configuration state
   logic [17:0] ctrl_q, ctrl_d;
   logic [11:0] div_q, div_d;
   logic [15:0] tse_q, tse_d, rse_q, rse_d;
   logic [15:0] tx_buf_q [4];
   logic [15:0] tx_buf_d [4];
   logic [31:0] rdata_q, rdata_d;

   // Engine state
   phase_t phase_q, phase_d;
   logic [3:0] slot_q, slot_d;
   logic [4:0] bit_q, bit_d;
   logic [1:0] ptr_q, ptr_d;
   logic [15:0] tx_sh_q, tx_sh_d, rx_sh_q, rx_sh_d;
   logic slot_tx_q, slot_tx_d;
   logic fs_prev_q, fs_prev_d, fs_out_q, fs_out_d;
   logic out_q, out_d, oe_n_q, oe_n_d;
   logic bck_prev_q, bck_prev_d;
   logic xfer_q, xfer_d;
   logic [15:0] tx_shadow_q [4];
   logic [15:0] tx_shadow_d [4];
   logic [15:0] rx_shadow_q [4];
   logic [15:0] rx_shadow_d [4];
   logic [15:0] rx_buf_q [4];
   logic [15:0] rx_buf_d [4];

   logic en, fs_slave, justify, idle_float, edge_rise, bclk_ext;
   logic [1:0] fmt, blen;
   logic [3:0] wlen, period, last_slot;
   logic [4:0] last_bit;
   logic gen_clk, bck, samp_edge, drv_edge, fs_src, trig, word_end, advance;
   logic wr, setup, mapped;

   assign en = ctrl_q[en_bit];
   assign fs_slave = ctrl_q[fs_dir_bit]; // R23
   assign fmt = ctrl_q[fmt_lo +: 2];
   assign justify = ctrl_q[justify_bit];
   assign idle_float = ctrl_q[idle_mode_bit];
   assign edge_rise = ctrl_q[edge_sel_bit];
   assign bclk_ext = ctrl_q[bclk_dir_bit];
   assign blen = ctrl_q[blen_lo +: 2];
   assign wlen = ctrl_q[wlen_lo +: 4];
   assign period = ctrl_q[period_lo +: 4];

   // The divider is masked when the clock comes from outside
   bit_clock_gen u_bclk (
      .pclk(pclk),
      .presetn(presetn),
      .divider(bclk_ext ? 12'h000 : div_q), // R9
      .clk_out(gen_clk)
   );

   assign bck = bclk_ext ? bit_clk_in : gen_clk;
   assign samp_edge = edge_rise ? (bck & ~bck_prev_q) : (~bck & bck_prev_q); // R10
   assign drv_edge = edge_rise ? (~bck & bck_prev_q) : (bck & ~bck_prev_q);
   assign fs_src = fs_slave ? frame_sync_in : fs_out_q; // R18
   // Sync is looked at only on sample edges
   assign trig = (fmt == fmt_i2s) ? (fs_src != fs_prev_q) : fs_src; // R2 R27

   // Frame shape per format
   always_comb begin
      unique case (fmt)
         fmt_ac16: begin // R25
            last_slot = ac16_last_slot;
            last_bit = (slot_q == 4'h0) ? tag_last_bit : ac_last_bit;
         end
         fmt_ac20: begin // R25
            last_slot = ac20_last_slot;
            last_bit = tag_last_bit;
         end
         default: begin
            last_slot = period;
            last_bit = {1'b0, wlen}; // R22 R24
         end
      endcase
   end

   assign word_end = (phase_q == st_run) && (bit_q == last_bit);
   assign advance = samp_edge && word_end && (tse_q[slot_q] || rse_q[slot_q]); // R20

   // APB register file; zero wait states
   assign setup = psel && !penable;
   assign wr = psel && penable && pwrite;
   assign mapped = (paddr[7:4] == tx_buf_page) || (paddr[7:4] == rx_buf_page) ||
                   (paddr == ctrl_one_off) || (paddr == ctrl_three_off) ||
                   (paddr == tx_slot_enable_off) || (paddr == rx_slot_enable_off) ||
                   (paddr == status_off);

   always_comb begin
      ctrl_d = ctrl_q;
      div_d = div_q;
      tse_d = tse_q;
      rse_d = rse_q;
      tx_buf_d = tx_buf_q;
      rdata_d = rdata_q;
      if (wr) begin
         if (paddr == ctrl_one_off) ctrl_d = pwdata[ctrl_one_w-1:0];
         if (paddr == ctrl_three_off) div_d = pwdata[11:0];
         if (paddr == tx_slot_enable_off) tse_d = pwdata[15:0];
         if (paddr == rx_slot_enable_off) rse_d = pwdata[15:0];
         if (paddr[7:4] == tx_buf_page) tx_buf_d[paddr[3:2]] = pwdata[15:0];
      end
      if (setup) begin
         rdata_d = 32'h0000_0000;
         if (paddr == ctrl_one_off) rdata_d[ctrl_one_w-1:0] = ctrl_q;
         if (paddr == ctrl_three_off) rdata_d[11:0] = div_q;
         if (paddr == tx_slot_enable_off) rdata_d[15:0] = tse_q;
         if (paddr == rx_slot_enable_off) rdata_d[15:0] = rse_q;
         if (paddr == status_off) rdata_d[6:0] = {ptr_q, phase_q == st_run, slot_q};
         if (paddr[7:4] == tx_buf_page) rdata_d[15:0] = tx_buf_q[paddr[3:2]];
         if (paddr[7:4] == rx_buf_page) rdata_d[15:0] = rx_buf_q[paddr[3:2]];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= ctrl_one_rst;
         div_q <= divider_rst;
         tse_q <= slot_en_rst;
         rse_q <= slot_en_rst;
         tx_buf_q <= '{default: 16'h0000};
         rdata_q <= 32'h0000_0000;
      end else begin
         ctrl_q <= ctrl_d;
         div_q <= div_d;
         tse_q <= tse_d;
         rse_q <= rse_d;
         tx_buf_q <= tx_buf_d;
         rdata_q <= rdata_d;
      end
   end

   assign prdata = rdata_q;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;

   // Serial engine
   always_comb begin
      phase_d = phase_q;
      slot_d = slot_q;
      bit_d = bit_q;
      ptr_d = ptr_q;
      tx_sh_d = tx_sh_q;
      rx_sh_d = rx_sh_q;
      slot_tx_d = slot_tx_q;
      fs_prev_d = fs_prev_q;
      fs_out_d = fs_out_q;
      out_d = out_q;
      oe_n_d = oe_n_q;
      tx_shadow_d = tx_shadow_q;
      rx_shadow_d = rx_shadow_q;
      rx_buf_d = rx_buf_q;
      xfer_d = 1'b0;
      bck_prev_d = bck;
      if (!en) begin
         // Disabling the block clears the slot, bit and pointer counters
         phase_d = st_idle;
         slot_d = 4'h0;
         bit_d = 5'h00;
         ptr_d = 2'h0;
         tx_sh_d = 16'h0000;
         rx_sh_d = 16'h0000;
         slot_tx_d = 1'b0;
         fs_prev_d = 1'b0;
         fs_out_d = 1'b0;
         out_d = 1'b0;
         oe_n_d = 1'b1;
      end else begin
         if (samp_edge) begin
            fs_prev_d = fs_src; // R27
            unique case (phase_q)
               st_idle: begin
                  if (trig) begin // R1 R2 R3 R18
                     phase_d = st_run;
                     slot_d = 4'h0;
                     slot_tx_d = tse_q[0];
                     tx_sh_d = tse_q[0] ? tx_shadow_q[ptr_q] : 16'h0000; // R12 R15
                     rx_sh_d = 16'h0000;
                     bit_d = 5'h00;
                     if (justify) begin // R11
                        // Bit 0 was already driven while idle, so skip it
                        rx_sh_d[15] = serial_in_pin;
                        tx_sh_d = {tx_sh_d[14:0], 1'b0};
                        bit_d = 5'h01;
                     end
                  end
               end
               st_run: begin
                  // Sync during a frame is ignored here on purpose
                  if (bit_q < 5'h10) rx_sh_d[~bit_q[3:0]] = serial_in_pin; // R17 R22
                  if (word_end) begin
                     if (rse_q[slot_q]) rx_shadow_d[ptr_q] = rx_sh_d; // R16
                     if (advance) begin
                        if (ptr_q == blen) begin // R21
                           ptr_d = 2'h0;
                           xfer_d = 1'b1;
                           rx_buf_d = rx_shadow_d;
                           tx_shadow_d = tx_buf_q;
                        end else begin
                           ptr_d = ptr_q + 2'h1; // R20
                        end
                     end
                     bit_d = 5'h00;
                     rx_sh_d = 16'h0000;
                     if (slot_q == last_slot) begin // R14 R19
                        phase_d = st_idle;
                        slot_tx_d = 1'b0;
                     end else begin
                        slot_d = slot_q + 4'h1;
                        slot_tx_d = tse_q[slot_d];
                        tx_sh_d = tse_q[slot_d] ? tx_shadow_d[ptr_d] : 16'h0000; // R12
                     end
                  end else begin
                     bit_d = bit_q + 5'h01; // R4
                  end
               end
            endcase
         end
         if (drv_edge) begin
            if (phase_q == st_run) begin
               // Low bits past the word length never leave the register
               out_d = slot_tx_q & tx_sh_q[15]; // R15
               tx_sh_d = {tx_sh_q[14:0], 1'b0};
               oe_n_d = idle_float && !slot_tx_q; // R13
            end else begin
               out_d = justify && tse_q[0] && tx_shadow_q[ptr_q][15];
               oe_n_d = idle_float && !(justify && tse_q[0]); // R13
            end
            if (!fs_slave) begin // R18 R23
               unique case (fmt)
                  fmt_multi: fs_out_d = (phase_q == st_idle);
                  fmt_i2s: fs_out_d = (phase_q == st_idle) ? ~fs_out_q : fs_out_q;
                  default: fs_out_d = (phase_q == st_idle) ||
                                      (slot_q == 4'h0 && bit_q < tag_last_bit);
               endcase
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase_q <= st_idle;
         slot_q <= 4'h0;
         bit_q <= 5'h00;
         ptr_q <= 2'h0;
         tx_sh_q <= 16'h0000;
         rx_sh_q <= 16'h0000;
         slot_tx_q <= 1'b0;
         fs_prev_q <= 1'b0;
         fs_out_q <= 1'b0;
         out_q <= 1'b0;
         oe_n_q <= 1'b1;
         bck_prev_q <= 1'b0;
         xfer_q <= 1'b0;
         tx_shadow_q <= '{default: 16'h0000};
         rx_shadow_q <= '{default: 16'h0000};
         rx_buf_q <= '{default: 16'h0000};
      end else begin
         phase_q <= phase_d;
         slot_q <= slot_d;
         bit_q <= bit_d;
         ptr_q <= ptr_d;
         tx_sh_q <= tx_sh_d;
         rx_sh_q <= rx_sh_d;
         slot_tx_q <= slot_tx_d;
         fs_prev_q <= fs_prev_d;
         fs_out_q <= fs_out_d;
         out_q <= out_d;
         oe_n_q <= oe_n_d;
         bck_prev_q <= bck_prev_d;
         xfer_q <= xfer_d;
         tx_shadow_q <= tx_shadow_d;
         rx_shadow_q <= rx_shadow_d;
         rx_buf_q <= rx_buf_d;
      end
   end

   assign bit_clk_out = gen_clk;
   assign bit_clk_oe_n = bclk_ext;
   assign frame_sync_out = fs_out_q;
   assign frame_sync_oe_n = fs_slave || !en;
   assign serial_out_pin = out_q;
   assign serial_out_oe_n = oe_n_q;
   assign buffer_event = xfer_q; // R26

   ptr_wrap_a: assert property (@(posedge pclk) disable iff (!presetn) // R21
      (en && advance && ptr_q == blen) |=> (ptr_q == 2'h0 && xfer_q))
      else $error("pointer did not wrap at buffer length");
   ptr_step_a: assert property (@(posedge pclk) disable iff (!presetn) // R20
      (en && advance && ptr_q != blen) |=> ptr_q == $past(ptr_q) + 2'h1)
      else $error("pointer did not step by one");
   frame_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // R4
      (en && samp_edge && phase_q == st_run && trig && !word_end) |=>
      (phase_q == st_run && slot_q == $past(slot_q)))
      else $error("sync restarted a running frame");
   start_delay_a: assert property (@(posedge pclk) disable iff (!presetn) // R1
      (en && samp_edge && phase_q == st_idle && trig && !justify) |=>
      (phase_q == st_run && bit_q == 5'h00 && slot_q == 4'h0))
      else $error("frame start misplaced");
   start_same_a: assert property (@(posedge pclk) disable iff (!presetn) // R11
      (en && samp_edge && phase_q == st_idle && trig && justify) |=>
      (bit_q == 5'h01 && rx_sh_q[15] == $past(serial_in_pin)))
      else $error("justified start lost its first bit");
   idle_zero_a: assert property (@(posedge pclk) disable iff (!presetn) // R13
      (en && drv_edge && phase_q == st_run && !slot_tx_q && !idle_float) |=>
      (!serial_out_pin && !serial_out_oe_n))
      else $error("disabled slot not driven low");
   rx_store_a: assert property (@(posedge pclk) disable iff (!presetn) // R16 R17
      (en && samp_edge && word_end && rse_q[slot_q] && bit_q < 5'h10) |=>
      rx_shadow_q[$past(ptr_q)][4'hF - $past(bit_q[3:0])] == $past(serial_in_pin))
      else $error("receive word not stored");
   shadow_swap_a: assert property (@(posedge pclk) disable iff (!presetn) // R21
      xfer_q |-> (rx_buf_q[0] == rx_shadow_q[0] && tx_shadow_q[0] == $past(tx_buf_q[0])))
      else $error("shadow transfer wrong");
   frame_end_a: assert property (@(posedge pclk) disable iff (!presetn) // R19
      (en && samp_edge && word_end && slot_q == last_slot) |=> phase_q == st_idle)
      else $error("frame ran past its last slot");

endmodule : codec_serial_engine

// [bench/codec_model.sv]
// Behavioural codec on the far side: makes bit clock, frame sync and serial data.
// Assumes pclk is far faster than the bit clock; a half period is four pclk cycles.
`timescale 1ns/100ps
module codec_model (
   // System clock
   input wire logic pclk,
   // From the engine
   input wire logic serial_out_pin,
   input wire logic serial_out_oe_n,
   // To the engine
   output logic bit_clk,
   output logic frame_sync,
   output logic serial_data
);
   logic raw_q = 1'b0;
   logic inv = 1'b0;
   logic quiet = 1'b0;
   logic [15:0] heard = 16'h0000;
   assign bit_clk = raw_q ^ inv;
   initial begin
      frame_sync = 1'b0;
      serial_data = 1'b0;
   end
   // Clock runs only inside frames, so the engine sees no edges while idle
   task automatic frame(input int w, input int nw, input logic [15:0] word,
                        input logic resync, input logic just);
      int b;
      int c;
      quiet <= 1'b1;
      for (c = 0; c <= w * nw - just; c++) begin
         frame_sync <= (c == 0) || (resync && c == 2);
         b = c - 1 + just;
         serial_data <= (b < 0) ? ~serial_data : word[15 - b % w];
         raw_q <= 1'b1;
         repeat (4) @(posedge pclk);
         heard <= {heard[14:0], serial_out_pin};
         quiet <= quiet & serial_out_oe_n;
         raw_q <= 1'b0;
         repeat (4) @(posedge pclk);
      end
      frame_sync <= 1'b0;
      // Released line must not keep showing the last bit
      serial_data <= ~serial_data;
      repeat (12) @(posedge pclk);
   endtask : frame
endmodule : codec_model

// [bench/tb.sv]
// Self-checking bench for the codec serial engine over APB with a codec model.
// Assumes the engine runs as slave on an external bit clock except in the divider test.
`timescale 1ns/100ps
module tb;
   import codec_serial_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, err, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic bit_clk_out, bit_clk_oe_n, frame_sync_out, frame_sync_oe_n, buffer_event;
   logic serial_out_pin, serial_out_oe_n, bclk, fsync, sdat, bclk_w, fsync_w;
   logic [15:0] prev_tx, mask, got;
   int bad_count, checks_done, cycles, events, i, n;
   typedef struct {logic [3:0] wl; logic [15:0] tx; logic [15:0] rx;} row_t;
   row_t rows [4] = '{'{4'hF, 16'hA5C3, 16'h9E37}, '{4'h3, 16'h7777, 16'hB123},
                      '{4'h0, 16'h8000, 16'hFFFF}, '{4'h7, 16'h1ABC, 16'h5A0F}};
   assign bclk_w = bit_clk_oe_n ? bclk : bit_clk_out;
   assign fsync_w = frame_sync_oe_n ? fsync : frame_sync_out;
   codec_serial_engine u_codec_serial_engine (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .bit_clk_in(bclk_w), .bit_clk_out(bit_clk_out),
      .bit_clk_oe_n(bit_clk_oe_n), .frame_sync_in(fsync_w), .frame_sync_out(frame_sync_out),
      .frame_sync_oe_n(frame_sync_oe_n), .serial_in_pin(sdat),
      .serial_out_pin(serial_out_pin), .serial_out_oe_n(serial_out_oe_n),
      .buffer_event(buffer_event));
   codec_model u_codec_model (.pclk(pclk), .serial_out_pin(serial_out_pin),
      .serial_out_oe_n(serial_out_oe_n), .bit_clk(bclk), .frame_sync(fsync),
      .serial_data(sdat));
   initial pclk = 1'b0;
   always #50 pclk = ~pclk;
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : end_of_test
   always @(posedge pclk) begin
      cycles++;
      if (buffer_event === 1'b1) begin
         events++;
      end
      if (cycles == 30000) begin
         bad_count++;
         end_of_test();
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // Slave sync, external bit clock, divider left at zero
   function automatic logic [31:0] cfg(input logic [3:0] wl);
      return 32'h0000_0083 | (32'(wl) << wlen_lo);
   endfunction : cfg
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      {bad_count, checks_done, cycles, events} = '0;
      prev_tx = 16'h0000;
      repeat (4) @(posedge pclk);
      chk({pready, bit_clk_oe_n, frame_sync_oe_n, serial_out_oe_n, buffer_event}, 5'b10110);
      chk(prdata, 32'h0000_0000);
      presetn <= 1'b1;
      for (i = 0; i < 5; i++) begin
         apb(1'b0, 8'(i * 4 + (i / 4) * 4), 32'h0000_0000);
         chk(rd, 32'h0000_0000);
         chk(32'(err), 32'(i == 4));
      end
      apb(1'b1, tx_slot_enable_off, 32'h0000_0001);
      apb(1'b1, rx_slot_enable_off, 32'h0000_0001);
      for (i = 0; i < 4; i++) begin
         n = rows[i].wl + 1;
         mask = 16'hFFFF << (16 - n);
         apb(1'b1, {tx_buf_page, 4'h0}, {16'h0000, rows[i].tx});
         apb(1'b1, ctrl_one_off, cfg(rows[i].wl));
         events = 0;
         u_codec_model.frame(n, 1, rows[i].rx, 1'b0, 1'b0);
         apb(1'b0, {rx_buf_page, 4'h0}, 32'h0000_0000);
         chk(rd, {16'h0000, rows[i].rx & mask});
         got = u_codec_model.heard << (16 - n);
         chk(got, prev_tx & mask);
         chk(32'(events), 1);
         prev_tx = rows[i].tx;
      end
      // Resync mid-frame, justified data, rising-edge sampling
      for (i = 0; i < 3; i++) begin
         u_codec_model.inv <= (i == 2);
         apb(1'b1, ctrl_one_off, cfg(4'hF) | 32'(i == 1) << justify_bit
             | 32'(i == 2) << edge_sel_bit);
         events = 0;
         u_codec_model.frame(16, 1, rows[i].rx, i == 0, i == 1);
         apb(1'b0, {rx_buf_page, 4'h0}, 32'h0000_0000);
         chk(rd, {16'h0000, rows[i].rx});
         chk(u_codec_model.heard, 16'h1ABC);
         chk(32'(events), 1);
      end
      u_codec_model.inv <= 1'b0;
      apb(1'b1, tx_slot_enable_off, 32'h0000_0000);
      for (i = 0; i < 2; i++) begin
         apb(1'b1, ctrl_one_off, cfg(4'hF) | 32'(i) << idle_mode_bit);
         u_codec_model.frame(16, 1, 16'h0F0F, 1'b0, 1'b0);
         chk(u_codec_model.quiet, 32'(i));
         if (i == 0) begin
            chk(u_codec_model.heard, 16'h0000);
         end
      end
      // I2S on a rising sync edge, then both link-protocol frames of 256 bits
      for (i = 1; i < 4; i++) begin
         apb(1'b1, ctrl_one_off, cfg(4'hF) | 32'(i) << fmt_lo);
         events = 0;
         u_codec_model.frame(16, (i == 1) ? 1 : 16, 16'hC3A5, 1'b0, 1'b0);
         apb(1'b0, {rx_buf_page, 4'h0}, 32'h0000_0000);
         chk(rd, 32'h0000_C3A5);
         apb(1'b0, status_off, 32'h0000_0000);
         chk(rd, 32'((i == 1) ? 4'h0 : (i == 2) ? ac16_last_slot : ac20_last_slot));
         chk(32'(events), 1);
      end
      // Two slots, one tx-only: the shared pointer must reach buffer length one and wrap in one frame
      apb(1'b1, tx_slot_enable_off, 32'h0000_0003);
      apb(1'b1, ctrl_one_off, cfg(4'hF) | 32'h0000_4100);
      events = 0;
      u_codec_model.frame(16, 2, 16'h2468, 1'b0, 1'b0);
      apb(1'b0, {rx_buf_page, 4'h0}, 32'h0000_0000);
      chk(rd, 32'h0000_2468);
      chk(32'(events), 1);
      apb(1'b1, ctrl_one_off, 32'h0000_0001);
      apb(1'b1, ctrl_three_off, 32'h0000_0003);
      repeat (2) @(posedge pclk);
      chk({frame_sync_oe_n, bit_clk_oe_n}, 2'b00);
      for (i = 0; i < 40 && bit_clk_out !== 1'b0; i++) @(posedge pclk);
      for (i = 0; i < 40 && bit_clk_out !== 1'b1; i++) @(posedge pclk);
      for (n = 0; n < 40 && bit_clk_out === 1'b1; n++) @(posedge pclk);
      chk(32'(n), 4);
      for (i = 0; i < 200 && frame_sync_out !== 1'b1; i++) @(posedge pclk);
      chk(32'(frame_sync_out), 1);
      for (i = 0; i < 200 && frame_sync_out !== 1'b0; i++) @(posedge pclk);
      chk(32'(frame_sync_out), 0);
      apb(1'b1, ctrl_three_off, 32'h0000_0000);
      repeat (10) @(posedge pclk);
      got[0] = bit_clk_out;
      n = 0;
      repeat (40) begin
         @(posedge pclk);
         n += (bit_clk_out !== got[0]);
      end
      chk(32'(n), 0);
      // Reset in mid-run returns pins and registers to their idle values
      presetn <= 1'b0;
      @(posedge pclk);
      chk({frame_sync_oe_n, serial_out_oe_n, buffer_event, bit_clk_out}, 4'b1100);
      presetn <= 1'b1;
      apb(1'b0, ctrl_one_off, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      end_of_test();
   end
endmodule : tb
